// file: rtl/cfd_params.svh
// Constants of the flow and data addressing core.
// Assumes inclusion by bare name from the package and the core.
`ifndef CFD_PARAMS_SVH
`define CFD_PARAMS_SVH
// File register map
`define CFD_ADDR_INDIRECT  8'h00
`define CFD_ADDR_RTC       8'h01
`define CFD_ADDR_PCL       8'h02
`define CFD_ADDR_STATUS    8'h03
`define CFD_ADDR_BANKPTR   8'h04
`define CFD_ADDR_PORT0     8'h05
`define CFD_NUM_PORTS      5
`define CFD_STACK_DEPTH    8
// Field positions
`define CFD_SEG_HI         7
`define CFD_SEG_LO         5
`define CFD_BANK_HI        6
`define CFD_BANK_LO        4
`define CFD_BLOCK_BIT      7
`define CFD_RDSRC_BIT      7
`define CFD_FR_GLOBAL_BIT  4
// Port configuration select codes held in the mode register
`define CFD_MODE_LEVEL     8'h1d
`define CFD_MODE_PULLUP    8'h1e
`define CFD_MODE_DIR       8'h1f
// Reset values
`define CFD_RST_PC         12'hfff
`define CFD_RST_MODE       8'h1f
`define CFD_RST_BANKPTR    8'h80
`define CFD_RST_CFG        8'hff
`define CFD_RST_BYTE       8'h00
`endif

// file: rtl/cfd_pkg.sv
// Types shared by the flow and data addressing core.
// Assumes the decoder upstream maps opcodes onto cfd_op_type.
`include "cfd_params.svh"
package cfd_pkg;
  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_W_LITERAL    = 5'h01,
    OP_FR_FROM_W    = 5'h02,
    OP_W_FROM_FR    = 5'h03,
    OP_INC          = 5'h04,
    OP_DEC          = 5'h05,
    OP_INC_SKIP_Z   = 5'h06,
    OP_DEC_SKIP_Z   = 5'h07,
    OP_BIT_SET      = 5'h08,
    OP_BIT_CLEAR    = 5'h09,
    OP_SKIP_IF_SET  = 5'h0a,
    OP_SKIP_IF_CLR  = 5'h0b,
    OP_BANK         = 5'h0c,
    OP_PAGE         = 5'h0d,
    OP_ABS_BRANCH   = 5'h0e,
    OP_SUB_BRANCH   = 5'h0f,
    OP_EXIT_PLAIN   = 5'h10,
    OP_EXIT_SEGMENT = 5'h11,
    OP_EXIT_ISR     = 5'h12,
    OP_EXIT_ISR_ADD = 5'h13,
    OP_EXIT_LITERAL = 5'h14,
    OP_MODE_LOAD    = 5'h15,
    OP_PORT_CFG_WR  = 5'h16,
    OP_PORT_CFG_RD  = 5'h17
  } cfd_op_type;
endpackage : cfd_pkg

// file: rtl/cfd_core.sv
// Operand addressing and program flow of the processor core.
// Assumes one decoded instruction per cycle; fetch discards on flush_out.
//
// Functional notes
// - Indirect operand register address acts on register named by bank pointer.
// - Bank operation writes pointer bits 6:4 in one cycle, low bits kept.
// - Pointer bit 7 picks lower or upper bank group in address forming.
// - Any data memory bit can be set, cleared and tested.
// - Each port has direction, input level and pull-up configuration registers.
// - Mode register selects config set; port move reads or writes it.
// - Read source bit chooses pins (0) or data registers (1) for ports.
// - Default read returns sampled pin level, data register ignored.
// - Increment or decrement skip zero updates register, skips on zero.
// - Eight entry hardware return-address stack.
// - Absolute branch takes nine address bits plus segment bits on top.
// - Segment operation sets page bits in one cycle, value 0 to 3.
// - Call pushes pc+1, loads eight bits, clears bit 8, segment on top.
// - Exit variants: plain, segment load, add to counter, literal load.
// - Push shifts every entry deeper, deepest lost, top gets return.
// - Pop loads pc from top, shifts up, deepest kept and duplicated.
// - Segment bits sit at status bits 7 to 5.
// - Low pc byte is file register 02h, bank pointer is 04h.
`timescale 1ns/1ps
`default_nettype none
`include "cfd_params.svh"
module cfd_core
  import cfd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        instr_valid_in,
  input  wire cfd_op_type  op_in,
  input  wire logic [4:0]  fr_field_in,
  input  wire logic [2:0]  bit_sel_in,
  input  wire logic [7:0]  literal_in,
  input  wire logic [8:0]  branch_addr_in,
  input  wire logic [7:0]  timer2_control_second_in,
  input  wire logic [39:0] port_pins_in,
  output logic      [39:0] port_data_out,
  output logic      [39:0] port_oe_out,
  output logic      [39:0] port_level_out,
  output logic      [39:0] port_pullup_out,
  output logic      [11:0] pc_out,
  output logic      [7:0]  w_out,
  output logic      [7:0]  bank_pointer_out,
  output logic      [7:0]  status_out,
  output logic      [7:0]  realtime_counter_out,
  output logic      [11:0] stack_top_out,
  output logic             flush_out
);
  // ****************************************
  // State
  // ****************************************
  logic [11:0] pc_reg;
  logic [7:0]  w_reg;
  logic [7:0]  bank_pointer_reg;
  logic [7:0]  status_reg;
  logic [7:0]  rtc_reg;
  logic [7:0]  mode_reg;
  logic [11:0] stack_reg [0:`CFD_STACK_DEPTH-1];
  logic [7:0]  mem_reg [0:255];
  logic [7:0]  pdata_reg [0:`CFD_NUM_PORTS-1];
  logic [7:0]  pdir_reg [0:`CFD_NUM_PORTS-1];
  logic [7:0]  plvl_reg [0:`CFD_NUM_PORTS-1];
  logic [7:0]  pplp_reg [0:`CFD_NUM_PORTS-1];
  logic [39:0] pin_s1_reg;
  logic [39:0] pin_s2_reg;
  logic [39:0] pin_s3_reg;
  logic [39:0] pin_stable_reg;

  // ****************************************
  // Pin input synchroniser
  // ****************************************
  // A pin change counts only once the second and third stages agree
  wire [39:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
  wire [39:0] pin_stable_next = (pin_agree & pin_s3_reg) | (~pin_agree & pin_stable_reg);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1_reg     <= '0;
      pin_s2_reg     <= '0;
      pin_s3_reg     <= '0;
      pin_stable_reg <= '0;
    end else begin
      pin_s1_reg     <= port_pins_in;
      pin_s2_reg     <= pin_s1_reg;
      pin_s3_reg     <= pin_s2_reg;
      pin_stable_reg <= pin_stable_next;
    end
  end

  // ****************************************
  // Operand address forming
  // ****************************************
  wire        go          = instr_valid_in;
  wire        fr_indirect = (fr_field_in == 5'h00);
  wire        fr_global   = ~fr_field_in[`CFD_FR_GLOBAL_BIT];
  // Upper half of the register field is banked through the pointer
  wire [7:0]  semi_addr   = {bank_pointer_reg[`CFD_BLOCK_BIT:`CFD_BANK_LO], fr_field_in[3:0]};
  wire [7:0]  eff_addr    = fr_indirect ? bank_pointer_reg
                          : fr_global ? {3'h0, fr_field_in} : semi_addr;
  wire [7:0]  port_off    = eff_addr - `CFD_ADDR_PORT0;
  wire        port_hit    = (eff_addr >= `CFD_ADDR_PORT0) && (port_off < 8'(`CFD_NUM_PORTS));
  wire [2:0]  port_idx    = port_off[2:0];
  wire        rd_src_data = timer2_control_second_in[`CFD_RDSRC_BIT];
  wire [7:0]  pin_byte    = pin_stable_reg[port_idx*8 +: 8];
  // Data register is read back only when the read source bit asks for it
  wire [7:0]  port_rd     = rd_src_data ? pdata_reg[port_idx] : pin_byte;

  // Operand read mux; the indirect register itself holds nothing
  wire [7:0]  rd_val = (eff_addr == `CFD_ADDR_INDIRECT) ? `CFD_RST_BYTE
                     : (eff_addr == `CFD_ADDR_RTC)      ? rtc_reg
                     : (eff_addr == `CFD_ADDR_PCL)      ? pc_reg[7:0]
                     : (eff_addr == `CFD_ADDR_STATUS)   ? status_reg
                     : (eff_addr == `CFD_ADDR_BANKPTR)  ? bank_pointer_reg
                     : port_hit                         ? port_rd
                     : mem_reg[eff_addr];

  // ****************************************
  // Operation decode
  // ****************************************
  wire [7:0] bit_mask  = 8'h01 << bit_sel_in;
  wire [7:0] inc_val   = rd_val + 8'h01;
  wire [7:0] dec_val   = rd_val - 8'h01;
  wire       is_inc    = (op_in == OP_INC) || (op_in == OP_INC_SKIP_Z);
  wire       is_dec    = (op_in == OP_DEC) || (op_in == OP_DEC_SKIP_Z);
  wire       is_bset   = (op_in == OP_BIT_SET);
  wire       is_bclr   = (op_in == OP_BIT_CLEAR);
  wire       wr_fr     = go && (is_inc || is_dec || is_bset || is_bclr || (op_in == OP_FR_FROM_W));
  wire [7:0] wr_val    = is_inc ? inc_val : is_dec ? dec_val
                       : is_bset ? (rd_val | bit_mask)
                       : is_bclr ? (rd_val & ~bit_mask) : w_reg;
  wire       bit_hit   = |(rd_val & bit_mask);
  wire       skip      = go && (((op_in == OP_INC_SKIP_Z) && (inc_val == 8'h00))
                             || ((op_in == OP_DEC_SKIP_Z) && (dec_val == 8'h00))
                             || ((op_in == OP_SKIP_IF_SET) && bit_hit)
                             || ((op_in == OP_SKIP_IF_CLR) && !bit_hit));
  wire       pop       = go && (op_in >= OP_EXIT_PLAIN) && (op_in <= OP_EXIT_LITERAL);
  wire       push      = go && (op_in == OP_SUB_BRANCH);
  wire       jump      = go && (op_in == OP_ABS_BRANCH);
  wire [2:0] seg_bits  = status_reg[`CFD_SEG_HI:`CFD_SEG_LO];
  wire [11:0] pc_inc   = pc_reg + 12'h001;
  // Flushed slot costs a cycle; fetch refills from pc_out
  assign flush_out = skip || pop || push || jump;

  // Program counter next value
  wire [11:0] pc_next = !go  ? pc_reg
                      : jump ? {seg_bits, branch_addr_in}
                      : push ? {seg_bits, 1'b0, literal_in}
                      : pop  ? stack_reg[0]
                      : skip ? pc_reg + 12'h002
                      : (wr_fr && eff_addr == `CFD_ADDR_PCL) ? {pc_reg[11:8], wr_val}
                      : pc_inc;

  // Port configuration register picked by the mode register
  wire        cfg_port_ok = port_hit;
  wire [7:0]  cfg_rd      = (mode_reg == `CFD_MODE_DIR)    ? pdir_reg[port_idx]
                          : (mode_reg == `CFD_MODE_LEVEL)  ? plvl_reg[port_idx]
                          : (mode_reg == `CFD_MODE_PULLUP) ? pplp_reg[port_idx] : `CFD_RST_BYTE;
  wire        cfg_wr      = go && (op_in == OP_PORT_CFG_WR) && cfg_port_ok;

  // ****************************************
  // Program counter, accumulator, pointer, status
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_reg <= `CFD_RST_PC;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // Accumulator sources; the plain exits leave it alone
  wire [7:0] w_next = !go ? w_reg
                    : (op_in == OP_W_FROM_FR) ? rd_val
                    : (op_in == OP_W_LITERAL) ? literal_in
                    : (op_in == OP_EXIT_LITERAL) ? literal_in
                    : (op_in == OP_PORT_CFG_RD && cfg_port_ok) ? cfg_rd
                    : w_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      w_reg <= `CFD_RST_BYTE;
    end else begin
      w_reg <= w_next;
    end
  end

  // Bank operation touches only the bank bits
  wire [7:0] bp_next = (go && op_in == OP_BANK)
                     ? {bank_pointer_reg[`CFD_BLOCK_BIT], literal_in[`CFD_BANK_HI:`CFD_BANK_LO],
                        bank_pointer_reg[3:0]}
                     : (wr_fr && eff_addr == `CFD_ADDR_BANKPTR) ? wr_val : bank_pointer_reg;

  // Segment bits from page operation, segment exit or a status write
  wire [7:0] st_next = (go && op_in == OP_PAGE) ? {1'b0, literal_in[1:0], status_reg[4:0]}
                     : (go && op_in == OP_EXIT_SEGMENT) ? {stack_reg[0][11:9], status_reg[4:0]}
                     : (wr_fr && eff_addr == `CFD_ADDR_STATUS) ? wr_val : status_reg;

  // Counter adds the accumulator to itself on the adding interrupt exit
  wire [7:0] rtc_next = (go && op_in == OP_EXIT_ISR_ADD) ? rtc_reg + w_reg
                      : (wr_fr && eff_addr == `CFD_ADDR_RTC) ? wr_val : rtc_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bank_pointer_reg <= `CFD_RST_BANKPTR;
      status_reg       <= `CFD_RST_BYTE;
      rtc_reg          <= `CFD_RST_BYTE;
      mode_reg         <= `CFD_RST_MODE;
    end else begin
      bank_pointer_reg <= bp_next;
      status_reg       <= st_next;
      rtc_reg          <= rtc_next;
      mode_reg         <= (go && op_in == OP_MODE_LOAD) ? literal_in : mode_reg;
    end
  end

  // ****************************************
  // Return stack
  // ****************************************
  // Deepest level is dropped on push and kept on pop
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < `CFD_STACK_DEPTH; i++) stack_reg[i] <= '0;
    end else if (push) begin
      stack_reg[0] <= pc_inc;
      for (int i = 1; i < `CFD_STACK_DEPTH; i++) stack_reg[i] <= stack_reg[i-1];
    end else if (pop) begin
      for (int i = 0; i < `CFD_STACK_DEPTH-1; i++) stack_reg[i] <= stack_reg[i+1];
    end
  end

  // ****************************************
  // Data memory and ports
  // ****************************************
  // General storage has no reset; mapped registers shadow it on reads
  always_ff @(posedge clk_in) begin
    if (wr_fr) begin
      mem_reg[eff_addr] <= wr_val;
    end
  end

  // Direction, level and pull-up per port, written through the mode select
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int p = 0; p < `CFD_NUM_PORTS; p++) begin
        pdata_reg[p] <= `CFD_RST_BYTE;
        pdir_reg[p]  <= `CFD_RST_CFG;
        plvl_reg[p]  <= `CFD_RST_CFG;
        pplp_reg[p]  <= `CFD_RST_CFG;
      end
    end else begin
      if (wr_fr && port_hit) pdata_reg[port_idx] <= wr_val;
      if (cfg_wr && mode_reg == `CFD_MODE_DIR) pdir_reg[port_idx] <= w_reg;
      if (cfg_wr && mode_reg == `CFD_MODE_LEVEL) plvl_reg[port_idx] <= w_reg;
      if (cfg_wr && mode_reg == `CFD_MODE_PULLUP) pplp_reg[port_idx] <= w_reg;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Direction bit 1 means input, so the pin is driven when it is 0
  for (genvar p = 0; p < `CFD_NUM_PORTS; p++) begin : g_port
    assign port_data_out[p*8 +: 8]   = pdata_reg[p];
    assign port_oe_out[p*8 +: 8]     = ~pdir_reg[p];
    assign port_level_out[p*8 +: 8]  = plvl_reg[p];
    assign port_pullup_out[p*8 +: 8] = pplp_reg[p] | ~pdir_reg[p];
  end
  assign pc_out               = pc_reg;
  assign w_out                = w_reg;
  assign bank_pointer_out     = bank_pointer_reg;
  assign status_out           = status_reg;
  assign realtime_counter_out = rtc_reg;
  assign stack_top_out        = stack_reg[0];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  a_indirect_addr: assert property (go && op_in == OP_FR_FROM_W && fr_indirect
    |=> mem_reg[$past(bank_pointer_reg)] == $past(w_reg))
    else $error("indirect operand not routed to pointer");
  a_bank_low_kept: assert property (go && op_in == OP_BANK |=>
    bank_pointer_reg[3:0] == $past(bank_pointer_reg[3:0]) && bank_pointer_reg[6:4] == $past(literal_in[6:4]))
    else $error("bank operation disturbed pointer");
  a_read_source: assert property (go && op_in == OP_W_FROM_FR && port_hit && rd_src_data
    |=> w_reg == $past(pdata_reg[port_idx]))
    else $error("port read ignored read source");
  a_skip_zero: assert property (go && op_in == OP_DEC_SKIP_Z && rd_val == 8'h01
    |-> flush_out ##1 pc_reg == $past(pc_reg) + 12'h002)
    else $error("zero result did not skip");
  a_jump_target: assert property (jump |=> pc_reg == {$past(seg_bits), $past(branch_addr_in)})
    else $error("absolute branch target wrong");
  a_page_bits: assert property (go && op_in == OP_PAGE |=> seg_bits == {1'b0, $past(literal_in[1:0])})
    else $error("segment bits not set");
  a_call_frame: assert property (push |=> pc_reg[8] == 1'b0 && stack_reg[0] == $past(pc_reg) + 12'h001)
    else $error("call frame wrong");
  a_push_deep: assert property (push |=> stack_reg[7] == $past(stack_reg[6]))
    else $error("push did not shift");
  a_pop_deep: assert property (pop |=> stack_reg[6] == stack_reg[7] && stack_reg[7] == $past(stack_reg[7]))
    else $error("pop lost deepest level");

  // Address forming, checked at the storage
  a_semi_addr: assert property (go && op_in == OP_FR_FROM_W && fr_field_in[`CFD_FR_GLOBAL_BIT] |=>
    mem_reg[{$past(bank_pointer_reg[`CFD_BLOCK_BIT:`CFD_BANK_LO]), $past(fr_field_in[`CFD_BANK_LO-1:0])}]
      == $past(w_reg))
    else $error("semidirect write missed");
  a_bit_set: assert property (go && is_bset
    |=> mem_reg[$past(eff_addr)] == ($past(rd_val) | $past(bit_mask)))
    else $error("bit set missed");

  // Ports
  a_pin_read: assert property (go && op_in == OP_W_FROM_FR && port_hit && !rd_src_data
    |=> w_reg == $past(pin_stable_reg[port_idx*8 +: 8]))
    else $error("pin level not read");
  a_dir_write: assert property (cfg_wr && mode_reg == `CFD_MODE_DIR
    |=> port_oe_out[$past(port_idx)*8 +: 8] == ~$past(w_reg))
    else $error("direction write lost");
  a_cfg_read: assert property (go && op_in == OP_PORT_CFG_RD && port_hit && mode_reg == `CFD_MODE_PULLUP
    |=> w_reg == $past(pplp_reg[port_idx]))
    else $error("pull-up read wrong");

  // Exits and skips
  a_exit_literal: assert property (go && op_in == OP_EXIT_LITERAL |=> w_reg == $past(literal_in))
    else $error("literal exit wrong");
  a_exit_keeps_w: assert property (go && (op_in == OP_EXIT_PLAIN || op_in == OP_EXIT_ISR)
    |=> w_reg == $past(w_reg))
    else $error("plain exit changed w");
  a_counter_add: assert property (go && op_in == OP_EXIT_ISR_ADD
    |=> rtc_reg == $past(rtc_reg) + $past(w_reg))
    else $error("counter add wrong");
  a_inc_skip: assert property (go && op_in == OP_INC_SKIP_Z && rd_val == 8'hff
    |-> flush_out ##1 pc_reg == $past(pc_reg) + 12'h002)
    else $error("increment skip missed");
  a_pop_target: assert property (pop |=> pc_reg == $past(stack_reg[0]))
    else $error("exit target wrong");
endmodule : cfd_core
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the flow and data addressing core.
// Assumes cfd_pkg is compiled first; the bench plays the upstream decoder.
`timescale 1ns/1ps
`default_nettype none
module tb
  import cfd_pkg::*;
;
  typedef struct {cfd_op_type op; logic [4:0] fr; logic [2:0] b; logic [7:0] lit, w, bp, st; logic skp;} cfd_row_type;
  logic        clk_in, reset_n_in, instr_valid_in, flush_out, fl;
  cfd_op_type  op_in;
  logic [4:0]  fr_field_in;
  logic [2:0]  bit_sel_in;
  logic [7:0]  literal_in, timer2_control_second_in, t2, w_out, bank_pointer_out, status_out, realtime_counter_out;
  logic [8:0]  branch_addr_in;
  logic [39:0] port_pins_in, pins, port_data_out, port_oe_out, port_level_out, port_pullup_out;
  logic [11:0] pc_out, stack_top_out, epc, p;
  logic [11:0] est [8];
  logic [7:0]  ew, es, ert;
  int          errors, cmp_count;
  cfd_row_type rows [$];
  cfd_op_type  eo [5] = '{OP_EXIT_PLAIN, OP_EXIT_SEGMENT, OP_EXIT_ISR, OP_EXIT_ISR_ADD, OP_EXIT_LITERAL};

  cfd_core i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .instr_valid_in(instr_valid_in), .op_in(op_in),
    .fr_field_in(fr_field_in), .bit_sel_in(bit_sel_in), .literal_in(literal_in), .branch_addr_in(branch_addr_in),
    .timer2_control_second_in(timer2_control_second_in), .port_pins_in(port_pins_in), .port_data_out(port_data_out),
    .port_oe_out(port_oe_out), .port_level_out(port_level_out), .port_pullup_out(port_pullup_out), .pc_out(pc_out),
    .w_out(w_out), .bank_pointer_out(bank_pointer_out), .status_out(status_out),
    .realtime_counter_out(realtime_counter_out), .stack_top_out(stack_top_out), .flush_out(flush_out));

  // ****************************************
  // Clock, compares and the instruction driver
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk_b(input logic [7:0] a, input logic [7:0] e, input string m);
    cmp_count++;
    if (a !== e) begin errors++; $display("[ERR] %0t %s got %h want %h", $time, m, a, e); end
  endtask : chk_b
  task automatic chk_a(input logic [11:0] a, input logic [11:0] e, input string m);
    cmp_count++;
    if (a !== e) begin errors++; $display("[ERR] %0t %s got %h want %h", $time, m, a, e); end
  endtask : chk_a
  task automatic chk_f(input logic a, input logic e, input string m);
    cmp_count++;
    if (a !== e) begin errors++; $display("[ERR] %0t %s got %b want %b", $time, m, a, e); end
  endtask : chk_f

  // Valid stays high between calls, so every cycle must go through ex
  task automatic ex(input cfd_op_type op, input logic [4:0] fr, input logic [2:0] b, input logic [7:0] lit,
                    input logic [8:0] ba);
    @(negedge clk_in);
    instr_valid_in = 1'b1; op_in = op; fr_field_in = fr; bit_sel_in = b; literal_in = lit; branch_addr_in = ba;
    timer2_control_second_in = t2; port_pins_in = pins;
    #1 fl = flush_out;
    @(posedge clk_in);
    #1 epc = epc + 12'h001;
  endtask : ex

  task automatic rw(input cfd_op_type op, input logic [4:0] fr, input logic [2:0] b, input logic [7:0] lit,
                    input logic [7:0] w, input logic [7:0] bp, input logic [7:0] st, input logic skp);
    rows.push_back('{op, fr, b, lit, w, bp, st, skp});
  endtask : rw

  // Values held while reset is asserted
  task automatic rst_chk();
    chk_a(pc_out, 12'hfff, "pc rst"); chk_b(w_out, 8'h00, "w rst"); chk_b(bank_pointer_out, 8'h80, "bank rst");
    chk_b(status_out, 8'h00, "status rst"); chk_a(stack_top_out, 12'h000, "stack rst");
    chk_b(port_oe_out[7:0], 8'h00, "oe rst"); chk_b(realtime_counter_out, 8'h00, "counter rst");
  endtask : rst_chk

  task automatic give_verdict();
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Whole run is under a hundred cycles; this only cuts a hang
  initial begin
    repeat (3000) @(posedge clk_in);
    errors++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset_n_in = 1'b0; instr_valid_in = 1'b0; op_in = OP_NOP; fr_field_in = 5'h00; bit_sel_in = 3'h0;
    literal_in = 8'h00; branch_addr_in = 9'h000; timer2_control_second_in = 8'h00; port_pins_in = 40'h0;
    t2 = 8'h00; pins = 40'h00_0000_003c; errors = 0; cmp_count = 0; epc = 12'hfff;
    rw(OP_W_LITERAL, 5'h00, 3'h0, 8'h5a, 8'h5a, 8'h80, 8'h00, 1'b0);
    rw(OP_FR_FROM_W, 5'h04, 3'h0, 8'h00, 8'h5a, 8'h5a, 8'h00, 1'b0);
    rw(OP_BANK, 5'h00, 3'h0, 8'h30, 8'h5a, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_LITERAL, 5'h00, 3'h0, 8'h77, 8'h77, 8'h3a, 8'h00, 1'b0);
    rw(OP_FR_FROM_W, 5'h00, 3'h0, 8'h00, 8'h77, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_LITERAL, 5'h00, 3'h0, 8'h00, 8'h00, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_FROM_FR, 5'h1a, 3'h0, 8'h00, 8'h77, 8'h3a, 8'h00, 1'b0);
    rw(OP_BIT_SET, 5'h1a, 3'h7, 8'h00, 8'h77, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_FROM_FR, 5'h00, 3'h0, 8'h00, 8'hf7, 8'h3a, 8'h00, 1'b0);
    rw(OP_BIT_CLEAR, 5'h00, 3'h0, 8'h00, 8'hf7, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_FROM_FR, 5'h1a, 3'h0, 8'h00, 8'hf6, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_LITERAL, 5'h00, 3'h0, 8'hba, 8'hba, 8'h3a, 8'h00, 1'b0);
    rw(OP_FR_FROM_W, 5'h04, 3'h0, 8'h00, 8'hba, 8'hba, 8'h00, 1'b0);
    rw(OP_W_LITERAL, 5'h00, 3'h0, 8'h11, 8'h11, 8'hba, 8'h00, 1'b0);
    rw(OP_FR_FROM_W, 5'h1a, 3'h0, 8'h00, 8'h11, 8'hba, 8'h00, 1'b0);
    rw(OP_W_LITERAL, 5'h00, 3'h0, 8'h3a, 8'h3a, 8'hba, 8'h00, 1'b0);
    rw(OP_FR_FROM_W, 5'h04, 3'h0, 8'h00, 8'h3a, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_FROM_FR, 5'h1a, 3'h0, 8'h00, 8'hf6, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_LITERAL, 5'h00, 3'h0, 8'hff, 8'hff, 8'h3a, 8'h00, 1'b0);
    rw(OP_FR_FROM_W, 5'h0a, 3'h0, 8'h00, 8'hff, 8'h3a, 8'h00, 1'b0);
    rw(OP_INC_SKIP_Z, 5'h0a, 3'h0, 8'h00, 8'hff, 8'h3a, 8'h00, 1'b1);
    rw(OP_INC_SKIP_Z, 5'h0a, 3'h0, 8'h00, 8'hff, 8'h3a, 8'h00, 1'b0);
    rw(OP_DEC_SKIP_Z, 5'h0a, 3'h0, 8'h00, 8'hff, 8'h3a, 8'h00, 1'b1);
    rw(OP_DEC_SKIP_Z, 5'h0a, 3'h0, 8'h00, 8'hff, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_FROM_FR, 5'h0a, 3'h0, 8'h00, 8'hff, 8'h3a, 8'h00, 1'b0);
    rw(OP_SKIP_IF_SET, 5'h0a, 3'h3, 8'h00, 8'hff, 8'h3a, 8'h00, 1'b1);
    rw(OP_SKIP_IF_CLR, 5'h0a, 3'h3, 8'h00, 8'hff, 8'h3a, 8'h00, 1'b0);
    rw(OP_INC, 5'h0a, 3'h0, 8'h00, 8'hff, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_FROM_FR, 5'h0a, 3'h0, 8'h00, 8'h00, 8'h3a, 8'h00, 1'b0);
    rw(OP_DEC, 5'h0a, 3'h0, 8'h00, 8'h00, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_FROM_FR, 5'h0a, 3'h0, 8'h00, 8'hff, 8'h3a, 8'h00, 1'b0);
    rw(OP_W_LITERAL, 5'h00, 3'h0, 8'h40, 8'h40, 8'h3a, 8'h00, 1'b0);
    rw(OP_FR_FROM_W, 5'h03, 3'h0, 8'h00, 8'h40, 8'h3a, 8'h40, 1'b0);
    rw(OP_PAGE, 5'h00, 3'h0, 8'h03, 8'h40, 8'h3a, 8'h60, 1'b0);
    rw(OP_W_LITERAL, 5'h00, 3'h0, 8'h33, 8'h33, 8'h3a, 8'h60, 1'b0);
    repeat (5) @(negedge clk_in);
    rst_chk();
    reset_n_in = 1'b1;
    // Ordinary cases: one instruction per row, pc tracked alongside
    foreach (rows[i]) begin
      ex(rows[i].op, rows[i].fr, rows[i].b, rows[i].lit, 9'h000);
      if (rows[i].skp) epc = epc + 12'h001;
      chk_b(w_out, rows[i].w, "w");
      chk_b(bank_pointer_out, rows[i].bp, "bank");
      chk_b(status_out, rows[i].st, "status");
      chk_a(pc_out, epc, "pc");
      chk_f(fl, rows[i].skp, "skip flush");
    end
    // Write of the low pc byte keeps the upper bits
    p = epc;
    ex(OP_FR_FROM_W, 5'h02, 3'h0, 8'h00, 9'h000);
    epc = {p[11:8], 8'h33};
    chk_a(pc_out, epc, "pc write");
    // Absolute branch with segment 3
    ex(OP_ABS_BRANCH, 5'h00, 3'h0, 8'h00, 9'h123);
    epc = 12'h723;
    chk_a(pc_out, epc, "jump");
    chk_f(fl, 1'b1, "jump flush");
    // Nine nested calls overflow the eight levels
    for (int i = 0; i < 9; i++) begin
      ex(OP_SUB_BRANCH, 5'h00, 3'h0, 8'h10 + 8'(i), 9'h000);
      for (int j = 7; j > 0; j--) est[j] = est[j-1];
      est[0] = epc;
      epc = {3'h3, 1'b0, 8'h10 + 8'(i)};
      chk_a(pc_out, epc, "call");
      chk_a(stack_top_out, est[0], "push");
      chk_f(fl, 1'b1, "call flush");
    end
    // Page 0 first, so the segment exit has something to restore
    ex(OP_PAGE, 5'h00, 3'h0, 8'h00, 9'h000);
    chk_b(status_out, 8'h00, "page 0");
    ew = 8'h33; es = 8'h00; ert = 8'h00;
    for (int i = 0; i < 9; i++) begin
      ex(eo[i % 5], 5'h00, 3'h0, 8'h30 + 8'(i), 9'h000);
      epc = est[0];
      for (int j = 0; j < 7; j++) est[j] = est[j+1];
      if (eo[i % 5] == OP_EXIT_SEGMENT) es[7:5] = epc[11:9];
      if (eo[i % 5] == OP_EXIT_ISR_ADD) ert = ert + ew;
      if (eo[i % 5] == OP_EXIT_LITERAL) ew = 8'h30 + 8'(i);
      chk_a(pc_out, epc, "pop pc");
      chk_a(stack_top_out, est[0], "pop shift");
      chk_b(w_out, ew, "exit w");
      chk_b(status_out, es, "exit segment");
      chk_b(realtime_counter_out, ert, "exit counter");
      chk_f(fl, 1'b1, "exit flush");
    end
    // Port configuration: W and literal agree, so either mode source works
    ex(OP_W_LITERAL, 5'h00, 3'h0, 8'h1f, 9'h000); ex(OP_MODE_LOAD, 5'h00, 3'h0, 8'h1f, 9'h000);
    ex(OP_W_LITERAL, 5'h00, 3'h0, 8'h0f, 9'h000); ex(OP_PORT_CFG_WR, 5'h05, 3'h0, 8'h00, 9'h000);
    chk_b(port_oe_out[7:0], 8'hf0, "direction");
    ex(OP_W_LITERAL, 5'h00, 3'h0, 8'h1d, 9'h000); ex(OP_MODE_LOAD, 5'h00, 3'h0, 8'h1d, 9'h000);
    ex(OP_W_LITERAL, 5'h00, 3'h0, 8'h3c, 9'h000); ex(OP_PORT_CFG_WR, 5'h06, 3'h0, 8'h00, 9'h000);
    chk_b(port_level_out[15:8], 8'h3c, "level");
    ex(OP_W_LITERAL, 5'h00, 3'h0, 8'h1e, 9'h000); ex(OP_MODE_LOAD, 5'h00, 3'h0, 8'h1e, 9'h000);
    ex(OP_W_LITERAL, 5'h00, 3'h0, 8'h55, 9'h000); ex(OP_PORT_CFG_WR, 5'h07, 3'h0, 8'h00, 9'h000);
    chk_b(port_pullup_out[23:16], 8'h55, "pullup");
    ex(OP_W_LITERAL, 5'h00, 3'h0, 8'h00, 9'h000); ex(OP_PORT_CFG_RD, 5'h07, 3'h0, 8'h00, 9'h000);
    chk_b(w_out, 8'h55, "cfg read");
    ex(OP_W_LITERAL, 5'h00, 3'h0, 8'ha5, 9'h000); ex(OP_FR_FROM_W, 5'h05, 3'h0, 8'h00, 9'h000);
    chk_b(port_data_out[7:0], 8'ha5, "port data");
    // No-op spacing also covers the pin synchroniser delay
    repeat (4) ex(OP_NOP, 5'h00, 3'h0, 8'h00, 9'h000);
    ex(OP_W_FROM_FR, 5'h05, 3'h0, 8'h00, 9'h000);
    chk_b(w_out, 8'h3c, "pin read");
    t2 = 8'h80;
    ex(OP_W_FROM_FR, 5'h05, 3'h0, 8'h00, 9'h000);
    chk_b(w_out, 8'ha5, "data read");
    // Second reset in mid-run, then execution resumes
    @(negedge clk_in);
    instr_valid_in = 1'b0;
    reset_n_in = 1'b0;
    #1 rst_chk();
    repeat (2) @(negedge clk_in);
    reset_n_in = 1'b1;
    epc = 12'hfff;
    ex(OP_W_LITERAL, 5'h00, 3'h0, 8'h42, 9'h000);
    chk_b(w_out, 8'h42, "w after reset");
    chk_a(pc_out, epc, "pc after reset");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
